/* File: dv/dcb_core_model.sv */
// far-side model of the sequencer, trace unit and cpu state
`default_nettype none
module dcb_core_model (
    input wire logic pclk,                          // bus clock
    input wire logic presetn,                       // async reset, low
    input wire dcb_pkg::dcb_core_out_t core_out,    // pulses from the block
    input wire logic [2:0] mode,                    // secure, bdm enable, bdm active
    input wire logic final_req,                     // sequencer in final state
    output dcb_pkg::dcb_core_in_t core_in           // state toward the block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] left;
    logic done;
    logic full;
    logic [6:0] cnt;
    // ***************************
    // trace session: four entries after each start, then buffer full
    // ***************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 3'h0;
            done <= 1'b0;
            full <= 1'b0;
            cnt <= 7'h00;
        end else begin
            done <= (left == 3'h1);
            if (core_out.trace_start) begin
                left <= 3'h4;
            end else if (left != 3'h0) begin
                left <= left - 3'h1;
                cnt <= cnt + 7'h01;
                full <= full | (left == 3'h1);
            end
        end
    end
    // fixed match and state flags so the shared register shows a known pattern
    assign core_in = '{secure: mode[2], bdm_enable: mode[1], bdm_active: mode[0],
        seq_final: final_req, tracing: (left != 3'h0), trace_done: done, trace_buffer_full: full,
        count: cnt, ssf: 3'h1, mfr: 3'h5};
endmodule
`default_nettype wire

/* File: dv/debug_control_bank_select_bench.sv */
// self-checking bench for the debug control and bank select block
`default_nettype none
module debug_control_bank_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, armed, irq;
    logic final_req, clr, err;
    logic [2:0] mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] seen;
    dcb_pkg::dcb_core_in_t core_in;
    dcb_pkg::dcb_core_out_t core_out;
    int fails = 0;
    int samples_checked = 0;
    dcb_debug_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_in(core_in), .core_out(core_out), .armed(armed), .irq(irq));
    dcb_core_model i_core (.pclk(pclk), .presetn(presetn), .core_out(core_out),
        .mode(mode), .final_req(final_req), .core_in(core_in));
    // ***************************
    // clock, pulse catcher, shared tasks
    // ***************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // one-cycle pulses are collected so a scenario can judge them afterwards
    always @(posedge pclk) seen <= clr ? 5'h00 : seen | core_out;
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    task automatic apb(input logic w, input logic [5:0] ix, input logic [7:0] wd);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            fails++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input string n, input logic [5:0] ix, input logic [7:0] e);
        apb(1'b0, ix, 8'h00);
        chk(n, {24'h000000, e}, rd);
    endtask
    task automatic sclr();
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
    endtask
    task automatic wait_disarm();
        int i;
        for (i = 0; i < 40 && armed !== 1'b0; i++) @(posedge pclk);
        if (armed !== 1'b0) begin
            fails++;
            results();
        end
    endtask
    // ***************************
    // scenarios
    // ***************************
    task automatic s_control();
        rchk("ctrl reset", dcb_pkg::IX_CTRL, 8'h00);
        apb(1'b1, dcb_pkg::IX_CTRL, 8'h5b);
        rchk("ctrl immediate_trigger_request reads zero", dcb_pkg::IX_CTRL, 8'h1b);
        apb(1'b1, dcb_pkg::IX_CTRL, 8'h00);
        sclr();
        apb(1'b1, dcb_pkg::IX_CTRL, 8'h98);
        @(posedge pclk);
        chk("seq restart", 32'h1, {31'h0, seen[4]});
        chk("armed", 32'h1, {31'h0, armed});
        apb(1'b1, dcb_pkg::IX_CTRL, 8'h81);
        rchk("ctrl locked bits", dcb_pkg::IX_CTRL, 8'h99);
        apb(1'b1, dcb_pkg::IX_TCR, 8'h40);
        rchk("tcr locked", dcb_pkg::IX_TCR, 8'h00);
        apb(1'b1, dcb_pkg::IX_CTRL, 8'h00);
        rchk("disarm keeps break bits", dcb_pkg::IX_CTRL, 8'h18);
        apb(1'b1, dcb_pkg::IX_CTRL, 8'h00);
        rchk("second write clears", dcb_pkg::IX_CTRL, 8'h00);
    endtask
    task automatic s_bank();
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, dcb_pkg::IX_CTRL, 8'(b));
            apb(1'b1, dcb_pkg::IX_SHR, 8'(5 + b));
            apb(1'b1, 6'h29, 8'(8'ha0 + b));
        end
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, dcb_pkg::IX_CTRL, 8'(b));
            rchk("shared reg", dcb_pkg::IX_SHR, (b < 3) ? 8'(5 + b) : 8'h05);
            rchk("window reg", 6'h29, (b < 3) ? 8'(8'ha0 + b) : 8'h00);
        end
    endtask
    task automatic s_final(input logic [2:0] m, input logic [7:0] c, input logic [4:0] e);
        mode <= m;
        apb(1'b1, dcb_pkg::IX_CTRL, c);
        sclr();
        final_req <= 1'b1;
        @(posedge pclk);
        final_req <= 1'b0;
        wait_disarm();
        repeat (2) @(posedge pclk);
        chk("final state pulses", {27'h0, e}, {27'h0, seen});
        chk("untraced break disarms", 32'h0, {31'h0, armed});
    endtask
    task automatic s_trace(input logic [2:0] m, input logic [4:0] e);
        mode <= m;
        apb(1'b1, dcb_pkg::IX_TCR, 8'h40);
        apb(1'b1, dcb_pkg::IX_CTRL, 8'h98);
        sclr();
        apb(1'b1, dcb_pkg::IX_CTRL, 8'hd8);
        wait_disarm();
        repeat (2) @(posedge pclk);
        chk("trigger pulses", {27'h0, e}, {27'h0, seen});
        chk("session ended", 32'h0, {31'h0, armed});
    endtask
    task automatic s_irq();
        apb(1'b0, dcb_pkg::IX_STAT, 8'h00);
        chk("full in status", 32'h1, {31'h0, rd[7]});
        apb(1'b0, dcb_pkg::IX_CNT, 8'h00);
        chk("full in count", 32'h1, {31'h0, rd[7]});
        rchk("irq status", dcb_pkg::IX_IST, 8'h07);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, dcb_pkg::IX_IMSK, 8'h02);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, dcb_pkg::IX_IST, 8'h02);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rchk("irq status w1c", dcb_pkg::IX_IST, 8'h05);
        apb(1'b0, 6'h3f, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, err});
    endtask
    // ***************************
    // main sequence
    // ***************************
    initial begin
        {psel, penable, pwrite, final_req, clr} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        mode = 3'h0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_control();
        s_bank();
        s_final(3'h0, 8'h88, 5'h09);
        s_final(3'h3, 8'h88, 5'h08);
        s_final(3'h2, 8'h98, 5'h0a);
        s_final(3'h0, 8'h98, 5'h09);
        s_trace(3'h2, 5'h0e);
        s_trace(3'h6, 5'h0a);
        s_irq();
        results();
    end
endmodule
`default_nettype wire

/* File: rtl/dcb_debug_ctrl.sv */
// debug control register, trigger, breakpoint routing and bank select
`default_nettype none
// Function
// - one comparator bank shown in window
// - armed: only arm, trigger, bank, irq status and mask writable
// - arm/bank anytime; break bits only disarmed
// - trigger bit reads zero, one requests
// - arm clears on session end or untraced trigger
// - arming restarts sequencer at first state
// - trigger immediate, else at final state
// - no tracing without trace source enable
// - begin-aligned running trace ignores immediate trigger request
// - secured chip never traces
// - trigger request counts only with arm set
// - break after tracing per enable and destination
// - destination set: background if enabled, else interrupt
// - destination clear: interrupt unless background active
// - final-state break at trace end or immediately
// - bank code picks comparator A, B, C, none
// - bank code picks shared register contents
// - buffer full bit in status and count
module dcb_debug_ctrl (
    input wire logic pclk,                          // bus clock
    input wire logic presetn,                       // async reset, low
    input wire logic psel,                          // apb select
    input wire logic penable,                       // apb access phase
    input wire logic pwrite,                        // apb direction
    input wire logic [7:0] paddr,                   // apb byte address
    input wire logic [31:0] pwdata,                 // apb write data
    output logic [31:0] prdata,                     // apb read data
    output logic pready,                            // apb ready
    output logic pslverr,                           // apb error
    input wire dcb_pkg::dcb_core_in_t core_in,      // sequencer, trace, cpu state
    output dcb_pkg::dcb_core_out_t core_out,        // pulses toward core
    output logic armed,                             // module armed
    output logic irq                                // interrupt level
);
    // ***************************
    // bus decode
    // ***************************
    dcb_pkg::dcb_state_t s, ns;
    logic [5:0] idx;
    logic setup;
    logic acc;
    logic wr;
    logic wr_ctl;
    logic [7:0] wb;
    logic trace_ok;
    logic imm;
    logic fire;
    logic brk_now;
    logic untraced;
    logic sess_end;
    logic [dcb_pkg::EV_W-1:0] ev;

    // ***************************
    // helpers
    // ***************************
    function automatic logic mapped(input logic [5:0] i);
        mapped = (i >= dcb_pkg::IX_CTRL) && (i <= dcb_pkg::IX_IMSK);
    endfunction

    // window rows share the upper index bits
    function automatic logic in_window(input logic [5:0] i);
        in_window = (i[5:3] == dcb_pkg::IX_WIN_HI);
    endfunction

    // bank code none hides every comparator bank
    function automatic logic bank_shown(input logic [1:0] b);
        bank_shown = (b != dcb_pkg::BANK_NONE);
    endfunction

    // zero wait states, so read data is captured in the setup cycle
    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign wr_ctl = wr && (idx == dcb_pkg::IX_CTRL);
    assign wb = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = acc && !mapped(idx);
    assign prdata = s.rdat;
    assign core_out = s.out;
    assign armed = s.ctl.arm;
    assign irq = s.irq;

    // ***************************
    // next state
    // ***************************
    always_comb begin
        ns = s;
        // pulses stand one cycle unless set again below
        ns.out = '0;
        trace_ok = s.tcr[dcb_pkg::B_TSE] && !core_in.secure;
        // trigger write only counts together with arm set
        imm = wr_ctl && wb[dcb_pkg::B_IMMEDIATE_TRIGGER_REQUEST] && wb[dcb_pkg::B_ARM];
        // begin-aligned trace already running swallows the request
        if (core_in.tracing && s.tcr[dcb_pkg::B_ALIGN] == dcb_pkg::ALIGN_BEGIN) begin
            imm = 1'b0;
        end
        fire = !s.immediate_trigger_request_done && (imm || (s.ctl.arm && core_in.seq_final));
        // control register: arm and bank always, break bits only disarmed
        if (wr_ctl) begin
            ns.ctl.arm = wb[dcb_pkg::B_ARM];
            ns.ctl.bank = wb[1:0];
            if (!s.ctl.arm) begin
                ns.ctl.dest = wb[dcb_pkg::B_DEST];
                ns.ctl.brk_en = wb[dcb_pkg::B_BRK];
            end
            // re-arming also re-opens the one trigger per session
            if (wb[dcb_pkg::B_ARM] && !s.ctl.arm) begin
                ns.out.seq_restart = 1'b1;
                ns.immediate_trigger_request_done = 1'b0;
            end
        end
        // trace control, shared and window registers locked while armed
        if (wr && !s.ctl.arm) begin
            if (idx == dcb_pkg::IX_TCR) begin
                ns.tcr = wb & dcb_pkg::TCR_WMASK;
            end
            // bank code none leaves every bank untouched
            if (idx == dcb_pkg::IX_SHR && bank_shown(s.ctl.bank)) begin
                ns.scr[s.ctl.bank] = wb[3:0];
            end
            if (in_window(idx) && bank_shown(s.ctl.bank)) begin
                ns.win[s.ctl.bank][idx[2:0]] = wb;
            end
        end
        // trigger and trace start; secured chip never traces
        if (fire) begin
            ns.immediate_trigger_request_done = 1'b1;
            ns.out.trigger = 1'b1;
            ns.out.trace_start = trace_ok;
        end
        // a trigger with no trace to run ends the session at once
        untraced = fire && !trace_ok;
        // trace unit reports the end of a session it ran for us
        sess_end = s.ctl.arm && core_in.trace_done;
        // final-state break: at trace end, or at once without tracing
        brk_now = s.ctl.brk_en && (untraced || sess_end);
        if (brk_now) begin
            if (s.ctl.dest) begin
                ns.out.brk_bg = core_in.bdm_enable;
                ns.out.brk_swi = !core_in.bdm_enable;
            end else begin
                ns.out.brk_swi = !core_in.bdm_active;
            end
        end
        // session over; after the control write so hardware clear wins
        if (sess_end || untraced) begin
            ns.ctl.arm = 1'b0;
        end
        // sticky events, write one to clear, set beats clear
        ev = {sess_end, brk_now, fire};
        if (wr && idx == dcb_pkg::IX_IST) begin
            ns.ist = s.ist & ~wb[dcb_pkg::EV_W-1:0];
        end
        if (wr && idx == dcb_pkg::IX_IMSK) begin
            ns.imsk = wb[dcb_pkg::EV_W-1:0];
        end
        // merged after the clear so a same-cycle event survives
        ns.ist = ns.ist | ev;
        ns.irq = |(ns.ist & ns.imsk);
        // read mux, sampled in setup so data stands for the access phase
        if (setup && !pwrite) begin
            ns.rdat = '0;
            case (idx)
                dcb_pkg::IX_CTRL: begin
                    ns.rdat[7:0] = {s.ctl.arm, 2'h0, s.ctl.dest, s.ctl.brk_en, 1'h0,
                                    s.ctl.bank};
                end
                dcb_pkg::IX_STAT: begin
                    ns.rdat[7:0] = {core_in.trace_buffer_full, 4'h0, core_in.ssf};
                end
                dcb_pkg::IX_TCR: begin
                    ns.rdat[7:0] = s.tcr;
                end
                dcb_pkg::IX_CNT: begin
                    ns.rdat[7:0] = {core_in.trace_buffer_full, core_in.count};
                end
                dcb_pkg::IX_SHR: begin
                    if (s.ctl.bank == dcb_pkg::BANK_NONE) begin
                        ns.rdat[7:0] = {5'h0, core_in.mfr};
                    end else begin
                        ns.rdat[7:0] = {4'h0, s.scr[s.ctl.bank]};
                    end
                end
                dcb_pkg::IX_IST: begin
                    ns.rdat[dcb_pkg::EV_W-1:0] = s.ist;
                end
                dcb_pkg::IX_IMSK: begin
                    ns.rdat[dcb_pkg::EV_W-1:0] = s.imsk;
                end
                default: begin
                    // window; bank code none shows zeros
                    if (in_window(idx) && bank_shown(s.ctl.bank)) begin
                        ns.rdat[7:0] = s.win[s.ctl.bank][idx[2:0]];
                    end
                end
            endcase
        end
    end

    // ***************************
    // state register
    // ***************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= ns;
        end
    end

    // ***************************
    // checks
    // ***************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // break bits frozen while armed
    chk_lock_brk: assert property (
        wr_ctl && s.ctl.arm |=> s.ctl.dest == $past(s.ctl.dest) &&
            s.ctl.brk_en == $past(s.ctl.brk_en))
        else $error("break bits changed while armed");
    chk_open_brk: assert property (
        wr_ctl && !s.ctl.arm |=> s.ctl.brk_en == $past(wb[dcb_pkg::B_BRK]) &&
            s.ctl.bank == $past(wb[1:0]))
        else $error("disarmed control write lost");
    chk_immediate_trigger_request_zero: assert property (
        acc && !pwrite && idx == dcb_pkg::IX_CTRL |-> !prdata[dcb_pkg::B_IMMEDIATE_TRIGGER_REQUEST])
        else $error("trigger bit read as one");
    chk_arm_done: assert property (
        s.ctl.arm && core_in.trace_done |=> !s.ctl.arm)
        else $error("arm not cleared at session end");
    chk_arm_restart: assert property (
        wr_ctl && wb[dcb_pkg::B_ARM] && !s.ctl.arm |=> core_out.seq_restart)
        else $error("no sequencer restart on arm");
    chk_imm_fire: assert property (
        wr_ctl && wb[dcb_pkg::B_ARM] && wb[dcb_pkg::B_IMMEDIATE_TRIGGER_REQUEST] && !s.immediate_trigger_request_done &&
            !core_in.tracing |=> core_out.trigger)
        else $error("immediate trigger missing");
    chk_begin_hold: assert property (
        wr_ctl && core_in.tracing && s.tcr[dcb_pkg::B_ALIGN] == dcb_pkg::ALIGN_BEGIN &&
            !(s.ctl.arm && core_in.seq_final) |=> !core_out.trigger)
        else $error("trigger during begin-aligned trace");
    chk_no_trace: assert property (
        core_out.trace_start |-> $past(s.tcr[dcb_pkg::B_TSE] && !core_in.secure))
        else $error("trace started while disabled");
    chk_end_brk: assert property (
        s.ctl.arm && core_in.trace_done && s.ctl.brk_en && !core_in.bdm_active &&
            !s.ctl.dest |=> core_out.brk_swi)
        else $error("final-state break missing");
    chk_bdm_route: assert property (
        core_out.brk_bg |-> $past(s.ctl.dest && core_in.bdm_enable))
        else $error("background break misrouted");
    chk_swi_route: assert property (
        core_out.brk_swi |-> $past(s.ctl.dest ? !core_in.bdm_enable : !core_in.bdm_active))
        else $error("interrupt break misrouted");
    chk_bank_none: assert property (
        acc && !pwrite && idx[5:3] == dcb_pkg::IX_WIN_HI &&
            s.ctl.bank == dcb_pkg::BANK_NONE |-> prdata == '0)
        else $error("window not empty for bank none");
    chk_tbf_mirror: assert property (
        acc && !pwrite && (idx == dcb_pkg::IX_STAT || idx == dcb_pkg::IX_CNT) |->
            prdata[dcb_pkg::B_TBF] == $past(core_in.trace_buffer_full))
        else $error("buffer full bit mismatch");

    // hardware disarms when a trigger has no trace to run
    chk_arm_untraced: assert property (
        fire && !trace_ok |=> !s.ctl.arm)
        else $error("arm kept after untraced trigger");
    // bank select follows every control write
    chk_bank_any: assert property (
        wr_ctl |=> s.ctl.bank == $past(wb[1:0]))
        else $error("bank select write lost");
    // destination taken while disarmed
    chk_dest_open: assert property (
        wr_ctl && !s.ctl.arm |=> s.ctl.dest == $past(wb[dcb_pkg::B_DEST]))
        else $error("destination write lost");
    // trace control frozen while armed
    chk_tcr_lock: assert property (
        wr && s.ctl.arm && idx == dcb_pkg::IX_TCR |=> s.tcr == $past(s.tcr))
        else $error("trace control changed while armed");
    // only writable trace control bits land
    chk_tcr_mask: assert property (
        wr && !s.ctl.arm && idx == dcb_pkg::IX_TCR |=> s.tcr == ($past(wb) & dcb_pkg::TCR_WMASK))
        else $error("trace control write wrong");
    // comparator banks frozen while armed
    chk_win_lock: assert property (
        wr && s.ctl.arm |=> s.win == $past(s.win) && s.scr == $past(s.scr))
        else $error("bank changed while armed");
    // bank code none writes nowhere
    chk_win_none_wr: assert property (
        wr && in_window(idx) && !bank_shown(s.ctl.bank) |=> s.win == $past(s.win))
        else $error("window write with bank none");
    // bank none shows the match flags at the shared index
    chk_shared_flags: assert property (
        acc && !pwrite && idx == dcb_pkg::IX_SHR && s.ctl.bank == dcb_pkg::BANK_NONE |->
            prdata[7:0] == {5'h0, $past(core_in.mfr)})
        else $error("match flags not shown");
    // restart only from a disarmed-to-armed write
    chk_restart_cause: assert property (
        core_out.seq_restart |-> $past(wr_ctl && wb[dcb_pkg::B_ARM] && !s.ctl.arm))
        else $error("spurious sequencer restart");
    // one trigger per arming
    chk_immediate_trigger_request_once: assert property (
        core_out.trigger |=> !core_out.trigger)
        else $error("trigger repeated");
    // a break needs the final-state enable
    chk_brk_needs_en: assert property (
        core_out.brk_bg || core_out.brk_swi |-> $past(s.ctl.brk_en))
        else $error("break without enable");
    // one destination per break
    chk_brk_excl: assert property (
        !(core_out.brk_bg && core_out.brk_swi))
        else $error("break sent to both destinations");
    // upper read bits stay zero
    chk_rd_upper: assert property (
        acc && !pwrite |-> prdata[31:8] == '0)
        else $error("upper read bits set");
    // trigger event latches in status
    chk_ist_set: assert property (
        fire |=> s.ist[0])
        else $error("trigger event not latched");
    // status holds until written with a one
    chk_ist_sticky: assert property (
        s.ist[0] && !(wr && idx == dcb_pkg::IX_IST && wb[0]) |=> s.ist[0])
        else $error("trigger event lost");

    // ***************************
    // cover points
    // ***************************
    cov_trigger: cover property (core_out.trigger ##1 !s.ctl.arm);
    cov_restart: cover property (core_out.seq_restart ##1 armed);
    cov_brk_bg: cover property (core_out.brk_bg);
    cov_brk_swi: cover property (core_out.brk_swi);
    cov_irq: cover property (irq);
endmodule
`default_nettype wire

/* File: rtl/dcb_pkg.sv */
// constants and types for the debug control and bank select block
`default_nettype none
package dcb_pkg;
    // ***************************
    // register indexes (byte address = index * 4)
    // ***************************
    localparam logic [5:0] IX_CTRL = 6'h20;
    localparam logic [5:0] IX_STAT = 6'h21;
    localparam logic [5:0] IX_TCR = 6'h22;
    localparam logic [5:0] IX_CNT = 6'h26;
    localparam logic [5:0] IX_SHR = 6'h27;
    localparam logic [2:0] IX_WIN_HI = 3'h5;   // 0x28..0x2f
    localparam logic [5:0] IX_IST = 6'h30;
    localparam logic [5:0] IX_IMSK = 6'h31;
    // ***************************
    // field positions and codes
    // ***************************
    localparam int B_ARM = 7;
    localparam int B_IMMEDIATE_TRIGGER_REQUEST = 6;
    localparam int B_DEST = 4;
    localparam int B_BRK = 3;
    localparam int B_TSE = 6;
    localparam int B_ALIGN = 0;
    localparam int B_TBF = 7;
    localparam logic [7:0] TCR_WMASK = 8'h4d;
    localparam logic ALIGN_BEGIN = 1'h0;
    localparam logic [1:0] BANK_NONE = 2'h3;
    localparam int EV_W = 3;
    // ***************************
    // carriers
    // ***************************
    typedef struct packed {
        logic arm;
        logic dest;
        logic brk_en;
        logic [1:0] bank;
    } dcb_ctl_t;
    typedef struct packed {
        logic secure;        // chip secured
        logic bdm_enable;    // background mode enabled
        logic bdm_active;    // background mode active
        logic seq_final;     // sequencer in final state
        logic tracing;       // trace session running
        logic trace_done;    // trace session completed
        logic trace_buffer_full;           // trace buffer full
        logic [6:0] count;   // trace entry count
        logic [2:0] ssf;     // sequencer state flags
        logic [2:0] mfr;     // match flags
    } dcb_core_in_t;
    typedef struct packed {
        logic seq_restart;   // put sequencer in first state
        logic trigger;
        logic trace_start;
        logic brk_bg;        // breakpoint into background mode
        logic brk_swi;       // breakpoint as software interrupt
    } dcb_core_out_t;
    typedef struct packed {
        dcb_ctl_t ctl;
        logic [7:0] tcr;
        logic [2:0][3:0] scr;
        logic [2:0][7:0][7:0] win;
        logic immediate_trigger_request_done;
        logic [EV_W-1:0] ist;
        logic [EV_W-1:0] imsk;
        logic irq;
        logic [31:0] rdat;
        dcb_core_out_t out;
    } dcb_state_t;
endpackage
`default_nettype wire
